// [core/bml_pkg.sv]
// Shared constants and types for the boot mode select loader
package bml_pkg;

   localparam int ADDR_W       = 20;
   localparam int INSTR_W      = 48;
   localparam int SRC_W        = 16;
   localparam int COUNT_W      = 9;
   localparam int BEAT_CNT_W   = 4;
   localparam int SYNC_SETTLE  = 2;

   // Kernel size in 48-bit instructions
   localparam logic [COUNT_W-1:0] KERNEL_WORDS = 9'h100;

   localparam logic [ADDR_W-1:0] START_STD    = 20'h2_0000;
   localparam logic [ADDR_W-1:0] START_RED    = 20'h0_8000;
   localparam logic [ADDR_W-1:0] START_WIDE   = 20'h4_0000;
   localparam logic [ADDR_W-1:0] RST_VEC_OFS  = 20'h0_0004;
   localparam logic [ADDR_W-1:0] NOBOOT_PC    = 20'h2_0004;

   localparam logic [3:0] CHAN_ZERO  = 4'h0;
   localparam logic [3:0] CHAN_SIX   = 4'h6;
   localparam logic [3:0] CHAN_EIGHT = 4'h8;
   localparam logic [3:0] CHAN_TEN   = 4'hA;

   // Beats per instruction for each source width
   localparam logic [BEAT_CNT_W-1:0] BEATS_BYTE   = 4'h6;
   localparam logic [BEAT_CNT_W-1:0] BEATS_HALF   = 4'h3;
   localparam logic [BEAT_CNT_W-1:0] BEATS_NIBBLE = 4'hC;
   localparam logic [5:0] BW_BYTE   = 6'h08;
   localparam logic [5:0] BW_HALF   = 6'h10;
   localparam logic [5:0] BW_NIBBLE = 6'h04;
   localparam logic [SRC_W-1:0] MASK_BYTE   = 16'h00FF;
   localparam logic [SRC_W-1:0] MASK_HALF   = 16'hFFFF;
   localparam logic [SRC_W-1:0] MASK_NIBBLE = 16'h000F;

   typedef enum logic [1:0] {
      BML_VAR_STD     = 2'h0,
      BML_VAR_REDUCED = 2'h1,
      BML_VAR_WIDE    = 2'h2
   } bml_variant_t;

   typedef enum logic [2:0] {
      BML_MODE_NOBOOT   = 3'h0,
      BML_MODE_HOST     = 3'h1,
      BML_MODE_LINK     = 3'h2,
      BML_MODE_EPROM    = 3'h3,
      BML_MODE_RESERVED = 3'h4
   } bml_mode_t;

   typedef enum logic [2:0] {
      BML_ST_SAMPLE = 3'h0,
      BML_ST_LOAD   = 3'h1,
      BML_ST_DRAIN  = 3'h2,
      BML_ST_RUN    = 3'h3,
      BML_ST_STOP   = 3'h4
   } bml_state_t;

   typedef struct packed {
      bml_mode_t  mode;
      logic [3:0] channel;
      logic [3:0] param_channel;
      logic       param_via_other;
      logic       host_width_8;
   } bml_boot_cfg_t;

   typedef struct packed {
      logic [ADDR_W-1:0]  addr;
      logic [INSTR_W-1:0] data;
   } bml_mem_word_t;

endpackage : bml_pkg

// [core/bml_pair_buffer.sv]
// Two-entry valid/ready buffer between packer and internal memory
`timescale 1ns/1ps
`default_nettype none
module bml_pair_buffer #(
   parameter int WIDTH = 68
) (
   input  wire logic             i_clock,
   input  wire logic             i_reset,
   input  wire logic             i_in_valid,
   output var  logic             o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output var  logic             o_out_valid,
   input  wire logic             i_out_ready,
   output var  logic [WIDTH-1:0] o_out_data
);
   typedef struct packed {
      logic [WIDTH-1:0] head;
      logic [WIDTH-1:0] tail;
      logic [1:0]       count;
   } bml_buf_state_t;

   bml_buf_state_t st_reg;
   bml_buf_state_t st_next;
   logic           push;
   logic           pop;

   assign o_in_ready  = (st_reg.count != 2'h2);
   assign o_out_valid = (st_reg.count != 2'h0);
   assign o_out_data  = st_reg.head;

   always_comb begin
      st_next = st_reg;
      push    = i_in_valid && o_in_ready;
      pop     = o_out_valid && i_out_ready;
      case ({push, pop})
         2'b10: begin
            if (st_reg.count == 2'h0) begin
               st_next.head = i_in_data;
            end else begin
               st_next.tail = i_in_data;
            end
            st_next.count = st_reg.count + 2'h1;
         end
         2'b01: begin
            st_next.head  = st_reg.tail;
            st_next.count = st_reg.count - 2'h1;
         end
         2'b11: begin
            // Count stays; with one entry the new word becomes the head
            if (st_reg.count == 2'h1) begin
               st_next.head = i_in_data;
            end else begin
               st_next.head = st_reg.tail;
               st_next.tail = i_in_data;
            end
         end
         default: begin
            st_next = st_reg;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : bml_pair_buffer
`default_nettype wire

// [core/bml_boot_loader.sv]
// Power-up boot mode decoder and boot kernel loader
`timescale 1ns/1ps
`default_nettype none
module bml_boot_loader #(
   parameter bml_pkg::bml_variant_t VARIANT = bml_pkg::BML_VAR_STD
) (
   input  wire logic                             i_clock,
   input  wire logic                             i_reset,
   input  wire logic                             i_rom_boot_strap,
   input  wire logic                             i_link_boot_strap,
   input  wire logic                             i_rom_boot_select_strap,
   input  wire logic                             i_boot_memory_select,
   output var  logic                             o_boot_memory_select,
   output var  logic                             o_boot_memory_select_oe,
   input  wire logic                             i_bus_master,
   input  wire logic                             i_src_valid,
   output var  logic                             o_src_ready,
   input  wire logic [bml_pkg::SRC_W-1:0]        i_src_data,
   output var  logic                             o_mem_valid,
   input  wire logic                             i_mem_ready,
   output var  bml_pkg::bml_mem_word_t           o_mem_word,
   output var  bml_pkg::bml_boot_cfg_t           o_boot_cfg,
   output var  logic                             o_dma_active,
   output var  logic                             o_core_halt,
   output var  logic                             o_core_start,
   output var  logic [bml_pkg::ADDR_W-1:0]       o_start_pc
);
   typedef struct packed {
      logic [3:0]                       sync1;
      logic [3:0]                       sync2;
      logic [1:0]                       settle;
      bml_pkg::bml_state_t              state;
      bml_pkg::bml_boot_cfg_t           cfg;
      logic [bml_pkg::INSTR_W-1:0]      pack;
      logic [bml_pkg::BEAT_CNT_W-1:0]   beat;
      logic                             word_full;
      logic [bml_pkg::ADDR_W-1:0]       addr;
      logic [bml_pkg::COUNT_W-1:0]      pushed;
      logic [bml_pkg::COUNT_W-1:0]      remain;
      logic [bml_pkg::ADDR_W-1:0]       start_pc;
      logic                             start_pulse;
      logic                             halt;
   } bml_ctl_t;

   bml_ctl_t                     r_reg;
   bml_ctl_t                     r_next;
   logic                         buf_in_ready;
   bml_pkg::bml_mem_word_t       buf_in_word;
   logic [bml_pkg::INSTR_W-1:0]  beat_ext;
   logic [5:0]                   beat_shift;
   logic                         src_fire;
   logic                         push_fire;
   logic                         mem_fire;

   // Strap decode into mode, DMA channel and host width
   function automatic bml_pkg::bml_boot_cfg_t decode_cfg(
      input logic rom, input logic link, input logic sel, input logic boot_memory_select);
      bml_pkg::bml_boot_cfg_t c;
      c = '0;
      if (VARIANT == bml_pkg::BML_VAR_REDUCED) begin
         c.channel         = bml_pkg::CHAN_EIGHT;
         c.param_channel   = bml_pkg::CHAN_ZERO;
         c.param_via_other = 1'b1;
         if (sel) begin
            c.mode = bml_pkg::BML_MODE_EPROM;
         end else if (boot_memory_select) begin
            c.mode         = bml_pkg::BML_MODE_HOST;
            c.host_width_8 = 1'b1;
         end else begin
            c.mode = bml_pkg::BML_MODE_NOBOOT;
         end
      end else begin
         if (rom) begin
            c.mode = link ? bml_pkg::BML_MODE_RESERVED
                          : bml_pkg::BML_MODE_EPROM;
         end else begin
            case ({link, boot_memory_select})
               2'b00:   c.mode = bml_pkg::BML_MODE_NOBOOT;
               2'b01:   c.mode = bml_pkg::BML_MODE_HOST;
               2'b11:   c.mode = bml_pkg::BML_MODE_LINK;
               default: c.mode = bml_pkg::BML_MODE_RESERVED;
            endcase
         end
         if (VARIANT == bml_pkg::BML_VAR_WIDE) begin
            c.channel = (c.mode == bml_pkg::BML_MODE_LINK) ?
                        bml_pkg::CHAN_EIGHT : bml_pkg::CHAN_TEN;
         end else begin
            c.channel = bml_pkg::CHAN_SIX;
         end
         c.param_channel = c.channel;
      end
      return c;
   endfunction : decode_cfg

   function automatic logic [bml_pkg::ADDR_W-1:0] start_addr();
      case (VARIANT)
         bml_pkg::BML_VAR_REDUCED: start_addr = bml_pkg::START_RED;
         bml_pkg::BML_VAR_WIDE:    start_addr = bml_pkg::START_WIDE;
         default:                  start_addr = bml_pkg::START_STD;
      endcase
   endfunction : start_addr

   // Source beat width: EPROM and 8-bit host are bytes, link is nibbles
   function automatic logic [5:0] beat_width(
      input bml_pkg::bml_boot_cfg_t c);
      if (c.mode == bml_pkg::BML_MODE_LINK) begin
         beat_width = bml_pkg::BW_NIBBLE;
      end else if (c.mode == bml_pkg::BML_MODE_HOST && !c.host_width_8) begin
         beat_width = bml_pkg::BW_HALF;
      end else begin
         beat_width = bml_pkg::BW_BYTE;
      end
   endfunction : beat_width

   function automatic logic [bml_pkg::BEAT_CNT_W-1:0] beats_per_word(
      input logic [5:0] bw);
      case (bw)
         bml_pkg::BW_NIBBLE: beats_per_word = bml_pkg::BEATS_NIBBLE;
         bml_pkg::BW_HALF:   beats_per_word = bml_pkg::BEATS_HALF;
         default:            beats_per_word = bml_pkg::BEATS_BYTE;
      endcase
   endfunction : beats_per_word

   function automatic logic [bml_pkg::SRC_W-1:0] beat_mask(
      input logic [5:0] bw);
      case (bw)
         bml_pkg::BW_NIBBLE: beat_mask = bml_pkg::MASK_NIBBLE;
         bml_pkg::BW_HALF:   beat_mask = bml_pkg::MASK_HALF;
         default:            beat_mask = bml_pkg::MASK_BYTE;
      endcase
   endfunction : beat_mask

   bml_pair_buffer #(
      .WIDTH ($bits(bml_pkg::bml_mem_word_t))
   ) u_buffer (
      .i_clock     (i_clock),
      .i_reset     (i_reset),
      .i_in_valid  (r_reg.word_full),
      .o_in_ready  (buf_in_ready),
      .i_in_data   (buf_in_word),
      .o_out_valid (o_mem_valid),
      .i_out_ready (i_mem_ready),
      .o_out_data  (o_mem_word)
   );

   assign buf_in_word = '{addr: r_reg.addr, data: r_reg.pack};
   // Low beat lands in the low bits: least significant first
   assign beat_shift  = 6'(r_reg.beat * beat_width(r_reg.cfg));
   assign beat_ext    = bml_pkg::INSTR_W'(i_src_data
                        & beat_mask(beat_width(r_reg.cfg))) << beat_shift;
   // Packer stalls the source while its word waits for buffer room
   assign o_src_ready = (r_reg.state == bml_pkg::BML_ST_LOAD)
                        && !r_reg.word_full
                        && (r_reg.pushed != bml_pkg::KERNEL_WORDS);
   assign src_fire    = i_src_valid && o_src_ready;
   assign push_fire   = r_reg.word_full && buf_in_ready;
   assign mem_fire    = o_mem_valid && i_mem_ready;

   always_comb begin
      r_next             = r_reg;
      r_next.sync1       = {i_rom_boot_strap, i_link_boot_strap,
                            i_rom_boot_select_strap, i_boot_memory_select};
      r_next.sync2       = r_reg.sync1;
      r_next.start_pulse = 1'b0;
      if (src_fire) begin
         r_next.pack = r_reg.pack | beat_ext;
         if (r_reg.beat == beats_per_word(beat_width(r_reg.cfg))
                           - 4'h1) begin
            r_next.beat      = '0;
            r_next.word_full = 1'b1;
         end else begin
            r_next.beat = r_reg.beat + 4'h1;
         end
      end
      if (push_fire) begin
         r_next.word_full = 1'b0;
         r_next.pack      = '0;
         r_next.addr      = r_reg.addr + 20'h0_0001;
         r_next.pushed    = r_reg.pushed + 9'h001;
      end
      if (mem_fire) begin
         r_next.remain = r_reg.remain - 9'h001;
      end
      case (r_reg.state)
         bml_pkg::BML_ST_SAMPLE: begin
            // Wait for the synchronisers to hold real pin levels
            if (r_reg.settle != 2'(bml_pkg::SYNC_SETTLE)) begin
               r_next.settle = r_reg.settle + 2'h1;
            end else begin
               r_next.cfg = decode_cfg(r_reg.sync2[3], r_reg.sync2[2],
                                       r_reg.sync2[1], r_reg.sync2[0]);
               r_next.addr   = start_addr();
               r_next.remain = bml_pkg::KERNEL_WORDS;
               r_next.pushed = '0;
               case (r_next.cfg.mode)
                  bml_pkg::BML_MODE_NOBOOT: begin
                     r_next.state       = bml_pkg::BML_ST_RUN;
                     r_next.start_pc    = bml_pkg::NOBOOT_PC;
                     r_next.start_pulse = 1'b1;
                     r_next.halt        = 1'b0;
                  end
                  bml_pkg::BML_MODE_RESERVED: begin
                     r_next.state = bml_pkg::BML_ST_STOP;
                  end
                  default: begin
                     r_next.state = bml_pkg::BML_ST_LOAD;
                  end
               endcase
            end
         end
         bml_pkg::BML_ST_LOAD: begin
            if (r_next.pushed == bml_pkg::KERNEL_WORDS) begin
               r_next.state = bml_pkg::BML_ST_DRAIN;
            end
         end
         bml_pkg::BML_ST_DRAIN: begin
            // Core stays halted until the last word is in memory
            if (r_next.remain == '0) begin
               r_next.state       = bml_pkg::BML_ST_RUN;
               r_next.halt        = 1'b0;
               r_next.start_pulse = 1'b1;
               // Jump to the kernel start address itself, where the first word was loaded
               r_next.start_pc    = start_addr();
            end
         end
         bml_pkg::BML_ST_RUN: begin
            r_next.state = bml_pkg::BML_ST_RUN;
         end
         bml_pkg::BML_ST_STOP: begin
            // Reserved straps: no transfer, core held until next reset
            r_next.halt = 1'b1;
         end
         default: begin
            r_next.state = bml_pkg::BML_ST_STOP;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         r_reg      <= '0;
         r_reg.halt <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_boot_cfg   = r_reg.cfg;
   assign o_dma_active = (r_reg.state == bml_pkg::BML_ST_LOAD)
                         || (r_reg.state == bml_pkg::BML_ST_DRAIN);
   assign o_core_halt  = r_reg.halt;
   assign o_core_start = r_reg.start_pulse;
   assign o_start_pc   = r_reg.start_pc;
   // Active-low EPROM select, low only while the kernel is fetched
   assign o_boot_memory_select = !(r_reg.state == bml_pkg::BML_ST_LOAD);
   // Pin stays an input in every other mode so the system can hold it
   assign o_boot_memory_select_oe =
      (r_reg.cfg.mode == bml_pkg::BML_MODE_EPROM)
      && (r_reg.state != bml_pkg::BML_ST_SAMPLE)
      && i_bus_master;
endmodule : bml_boot_loader
`default_nettype wire

// [tb/bml_checker.sv]
// Port-level assertions for the boot mode select loader
`timescale 1ns/1ps
`default_nettype none
module bml_checker #(
   parameter bml_pkg::bml_variant_t VARIANT = bml_pkg::BML_VAR_STD
) (
   input wire logic                          i_clock,
   input wire logic                          i_reset,
   input wire logic                          i_bus_master,
   input wire logic                          i_mem_ready,
   input wire logic                          o_boot_memory_select,
   input wire logic                          o_boot_memory_select_oe,
   input wire logic                          o_src_ready,
   input wire logic                          o_mem_valid,
   input wire bml_pkg::bml_mem_word_t        o_mem_word,
   input wire bml_pkg::bml_boot_cfg_t        o_boot_cfg,
   input wire logic                          o_dma_active,
   input wire logic                          o_core_halt,
   input wire logic                          o_core_start,
   input wire logic [bml_pkg::ADDR_W-1:0]    o_start_pc
);
   localparam logic [19:0] START =
      (VARIANT == bml_pkg::BML_VAR_REDUCED) ? bml_pkg::START_RED :
      (VARIANT == bml_pkg::BML_VAR_WIDE) ? bml_pkg::START_WIDE :
      bml_pkg::START_STD;
   logic       noboot;
   logic [8:0] taken_reg;
   assign noboot = (o_boot_cfg.mode == bml_pkg::BML_MODE_NOBOOT);
   // Words handed to internal memory since reset
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         taken_reg <= 9'h000;
      end else if (o_mem_valid && i_mem_ready) begin
         taken_reg <= taken_reg + 9'h001;
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   oe_owner_only_a:
   assert property (o_boot_memory_select_oe |-> i_bus_master &&
      o_boot_cfg.mode == bml_pkg::BML_MODE_EPROM) else $error("pin driven");
   select_in_load_a:
   assert property (!o_boot_memory_select |-> o_dma_active)
      else $error("select low outside load");
   halt_in_dma_a:
   assert property (o_dma_active |-> o_core_halt) else $error("core ran");
   start_after_count_a:
   assert property (o_core_start |-> taken_reg == 9'h100 || noboot)
      else $error("start before full kernel");
   start_pc_right_a:
   assert property (o_core_start |->
      o_start_pc == (noboot ? bml_pkg::NOBOOT_PC : START))
      else $error("wrong start address");
   start_single_a:
   assert property (o_core_start |=> !o_core_start && !o_core_halt)
      else $error("start pulse wrong");
   halt_release_cause_a:
   assert property ($fell(o_core_halt) |-> o_core_start)
      else $error("halt dropped without start");
   word_order_a:
   assert property (o_mem_valid |-> o_mem_word.addr == START + taken_reg)
      else $error("word address out of order");
   word_hold_a:
   assert property (o_mem_valid && !i_mem_ready |=>
      o_mem_valid && $stable(o_mem_word)) else $error("word dropped");
   no_extra_words_a:
   assert property (taken_reg == 9'h100 |-> !o_mem_valid && !o_src_ready)
      else $error("transfer past kernel size");
   reserved_idle_a:
   assert property (o_boot_cfg.mode == bml_pkg::BML_MODE_RESERVED |->
      !o_src_ready && !o_dma_active && o_core_halt) else $error("reserved ran");
   cfg_held_a:
   assert property (o_boot_cfg != '0 |=> $stable(o_boot_cfg))
      else $error("mode changed");
endmodule : bml_checker
bind bml_boot_loader bml_checker #(.VARIANT(VARIANT)) u_checker (.*);
`default_nettype wire

// [tb/bml_source_model.sv]
// Boot source model: rom, host or link peer feeding beats
`timescale 1ns/1ps
`default_nettype none
module bml_source_model (
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic        i_slow,
   input  wire logic [3:0]  i_beats,
   input  wire logic        i_ready,
   output var  logic        o_valid,
   output var  logic [15:0] o_data
);
   int          n_reg = 0;
   logic [15:0] beat;
   initial o_valid = 1'b0;
   // Word four sits at the reset vector and is a no-op
   assign beat = (n_reg / i_beats == 4) ? 16'h0000 :
      16'(n_reg * 16'h0125 + 16'h1A3C);
   // Released data lines show no stale beat
   assign o_data = o_valid ? beat : ~beat;
   always @(posedge i_clock) begin
      if (i_reset) begin
         n_reg <= #1 0;
         o_valid <= #1 1'b0;
      end else if (o_valid && i_ready) begin
         n_reg <= #1 n_reg + 1;
         o_valid <= #1 !i_slow;
      end else begin
         o_valid <= #1 1'b1;
      end
   end
endmodule : bml_source_model
`default_nettype wire

// [tb/boot_mode_select_loader_test.sv]
// Self-checking bench for the boot mode select loader
`timescale 1ns/1ps
`default_nettype none
module boot_mode_select_loader_test;
   logic                   i_clock, i_reset, i_rom_boot_strap;
   logic                   i_link_boot_strap, i_rom_boot_select_strap;
   logic                   i_boot_memory_select, i_bus_master, i_src_valid;
   logic                   i_mem_ready, o_src_ready, o_mem_valid;
   logic                   o_boot_memory_select, o_boot_memory_select_oe;
   logic                   o_dma_active, o_core_halt, o_core_start;
   logic                   bms_drv, slow;
   logic [15:0]            i_src_data;
   logic [19:0]            o_start_pc;
   logic [3:0]             beats;
   bml_pkg::bml_mem_word_t o_mem_word;
   bml_pkg::bml_boot_cfg_t o_boot_cfg;
   int                     mismatches, n_tests, cyc;
   bml_pkg::bml_boot_cfg_t red_cfg;
   logic                   red_pin, red_bms, red_oe, red_halt;
   logic [19:0]            red_pc;

   // Outside drives the pin from bms_drv unless the loader drives it
   assign i_boot_memory_select =
      o_boot_memory_select_oe ? o_boot_memory_select : bms_drv;
   bml_boot_loader #(.VARIANT(bml_pkg::BML_VAR_STD)) dut (.*);
   bml_source_model src (.i_clock(i_clock), .i_reset(i_reset),
      .i_slow(slow), .i_beats(beats), .i_ready(o_src_ready),
      .o_valid(i_src_valid), .o_data(i_src_data));

   // Reduced variant beside it; no source, so only its decode, select pin and no-boot start are judged
   assign red_pin = red_oe ? red_bms : bms_drv;
   bml_boot_loader #(.VARIANT(bml_pkg::BML_VAR_REDUCED)) dut_red (
      .i_clock(i_clock), .i_reset(i_reset),
      .i_rom_boot_strap(i_rom_boot_strap),
      .i_link_boot_strap(i_link_boot_strap),
      .i_rom_boot_select_strap(i_rom_boot_select_strap),
      .i_boot_memory_select(red_pin), .o_boot_memory_select(red_bms),
      .o_boot_memory_select_oe(red_oe), .i_bus_master(i_bus_master),
      .i_src_valid(1'b0), .o_src_ready(), .i_src_data(16'h0000),
      .o_mem_valid(), .i_mem_ready(1'b1), .o_mem_word(),
      .o_boot_cfg(red_cfg), .o_dma_active(), .o_core_halt(red_halt),
      .o_core_start(), .o_start_pc(red_pc));

   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cyc++;
      if (cyc > 20000) begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (mismatches == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [67:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [15:0] pat(input int n, input int b);
      return (n / b == 4) ? 16'h0000 : 16'(n * 16'h0125 + 16'h1A3C);
   endfunction : pat

   // Straps are set during reset and held; decode lands three edges later
   task automatic boot(input logic r, l, s, input logic [3:0] b,
                       input logic sl);
      @(posedge i_clock);
      #1;
      i_reset = 1'b1;
      {i_rom_boot_strap, i_link_boot_strap, bms_drv} = {r, l, s};
      {beats, slow, i_mem_ready, i_bus_master} = {b, sl, 2'b01};
      repeat (2) @(posedge i_clock);
      #1 i_reset = 1'b0;
      repeat (5) @(posedge i_clock);
      #1;
   endtask : boot

   // Every fourth word the memory stalls for four cycles before it takes the word
   task automatic run_load(input logic r, l, s, input bml_pkg::bml_mode_t m,
      input logic [3:0] b, input int bw, input logic [15:0] mk,
      input logic sl);
      logic [47:0] exp;
      int          g;
      boot(r, l, s, b, sl);
      check("mode", o_boot_cfg.mode, m);
      for (int w = 0; w < 256; w++) begin
         exp = '0;
         for (int k = 0; k < b; k++) begin
            exp |= 48'(pat(w * b + k, b) & mk) << (k * bw);
         end
         i_mem_ready = (w % 4 != 0);
         g = 0;
         while (!(o_mem_valid && i_mem_ready) && g < 60) begin
            @(posedge i_clock);
            #1 g++;
            i_mem_ready = (w % 4 != 0) || (g > 3);
         end
         check("halt", o_core_halt, 1'b1);
         check("word", o_mem_word, {bml_pkg::START_STD + 20'(w), exp});
         @(posedge i_clock);
         #1;
      end
      g = 0;
      while (o_core_start !== 1'b1 && g < 4) begin
         @(posedge i_clock);
         #1 g++;
      end
      check("start", {o_core_start, o_core_halt}, 2'b10);
      check("pc", o_start_pc, bml_pkg::START_STD);
      repeat (20) @(posedge i_clock);
      #1 check("after", {o_src_ready, o_mem_valid}, 2'b00);
   endtask : run_load

   task automatic t_reserved();
      for (int i = 0; i < 2; i++) begin
         boot(i == 0, 1'b1, i == 0, 4'h6, 1'b0);
         repeat (20) @(posedge i_clock);
         #1 check("mode", o_boot_cfg.mode, bml_pkg::BML_MODE_RESERVED);
         check("idle", {o_core_halt, o_src_ready, o_dma_active,
            o_boot_memory_select_oe}, 4'b1000);
      end
   endtask : t_reserved

   task automatic t_noboot();
      boot(1'b0, 1'b0, 1'b0, 4'h6, 1'b0);
      check("mode", o_boot_cfg.mode, bml_pkg::BML_MODE_NOBOOT);
      check("pc", o_start_pc, bml_pkg::NOBOOT_PC);
      check("run", {o_core_halt, o_boot_memory_select_oe}, 2'b00);
   endtask : t_noboot

   task automatic t_eprom();
      boot(1'b1, 1'b0, 1'b0, 4'h6, 1'b0);
      check("chan", o_boot_cfg.channel, bml_pkg::CHAN_SIX);
      check("cs", {o_boot_memory_select_oe, i_boot_memory_select},
         2'b10);
      i_bus_master = 1'b0;
      #1 check("oe", o_boot_memory_select_oe, 1'b0);
      run_load(1'b1, 1'b0, 1'b0, bml_pkg::BML_MODE_EPROM, 4'h6, 8,
         16'h00FF, 1'b0);
   endtask : t_eprom

   task automatic t_host();
      run_load(1'b0, 1'b0, 1'b1, bml_pkg::BML_MODE_HOST, 4'h3, 16,
         16'hFFFF, 1'b1);
   endtask : t_host

   task automatic t_link();
      run_load(1'b0, 1'b1, 1'b1, bml_pkg::BML_MODE_LINK, 4'hC, 4,
         16'h000F, 1'b0);
   endtask : t_link

   // Reduced variant: select strap wins, else the pin picks host or no-boot
   task automatic t_reduced();
      i_rom_boot_select_strap = 1'b1;
      boot(1'b0, 1'b0, 1'b1, 4'h6, 1'b0);
      check("red mode", red_cfg.mode, bml_pkg::BML_MODE_EPROM);
      check("red cs", {red_oe, red_bms}, 2'b10);
      i_rom_boot_select_strap = 1'b0;
      boot(1'b0, 1'b0, 1'b1, 4'h6, 1'b0);
      check("red host", red_cfg, {bml_pkg::BML_MODE_HOST,
         bml_pkg::CHAN_EIGHT, bml_pkg::CHAN_ZERO, 2'b11});
      boot(1'b0, 1'b0, 1'b0, 4'h6, 1'b0);
      check("red mode", red_cfg.mode, bml_pkg::BML_MODE_NOBOOT);
      check("red pc", {red_pc, red_halt}, {bml_pkg::NOBOOT_PC, 1'b0});
   endtask : t_reduced

   initial begin
      {i_reset, i_rom_boot_strap, i_link_boot_strap} = 3'b100;
      i_rom_boot_select_strap = 1'b0;
      {bms_drv, i_bus_master, i_mem_ready, slow} = 4'b1100;
      beats = 4'h6;
      mismatches = 0;
      n_tests = 0;
      cyc = 0;
      repeat (2) @(posedge i_clock);
      t_reserved();
      t_noboot();
      t_eprom();
      t_host();
      t_link();
      t_reduced();
      report_and_stop();
   end
endmodule : boot_mode_select_loader_test
`default_nettype wire
